// ==== logic/abm_master.sv ====
// Bus master port: turns user requests into bus transfers and answers.
// Assumes all inputs are synchronous to MCLK_I and reset is released
// synchronously by the surrounding system.

// Functional notes
// - Drive 32-bit byte address per transfer.
// - Burst only SINGLE, INCR, INCR4, INCR8.
// - Request bus whenever a transfer is needed.
// - Take bus only on grant and ready.
// - No other master granted while locked.
// - Lock during atomic swap to bus space.
// - Protection bit 0: fetch low, data high.
// - Protection bit 1: user low, privileged high.
// - Protection bits 2,3: bufferable, cacheable.
// - Slave returns 32-bit read data.
// - Transfer completes only when ready sampled high.
// - Active-low reset, released synchronously; RST_I here is active high.
// - Decode OKAY, ERROR, RETRY, SPLIT responses; here every response other than OKAY is taken as an error.
// - Size byte, halfword, word; bit 2 low.
// - Mark each cycle IDLE/BUSY/NONSEQ/SEQ.
// - Drive store data on write data bus.
// - Direction high for write, low read.
// - System asserts enable before bus edges.
// - Outputs change after, inputs sampled, rising edge.
module abm_master #(
    parameter int BEATS_MAX = 8
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    abm_if.master            bus,
    input  wire logic        REQ_VALID_I,
    output logic             REQ_READY_O,
    input  wire logic [31:0] REQ_ADDR_I,
    input  wire logic        REQ_WRITE_I,
    input  wire logic [1:0]  REQ_SIZE_I,
    input  wire logic [3:0]  REQ_BEATS_I,
    input  wire logic        REQ_FETCH_I,
    input  wire logic        REQ_PRIV_I,
    input  wire logic        REQ_BUF_I,
    input  wire logic        REQ_CACH_I,
    input  wire logic        REQ_SWAP_I,
    input  wire logic [31:0] REQ_WDATA_I,
    output logic             RSP_VALID_O,
    output logic [31:0]      RSP_RDATA_O,
    output logic             RSP_ERROR_O
);
    // Elaboration check: BEATS_MAX must be 8, the longest fixed burst code; counts up to 15 go out as INCR.
    if (BEATS_MAX != 8) begin : g_beats_check
        $error("BEATS_MAX must be 8");
    end

    typedef enum logic [2:0] {
        ABM_IDLE = 3'h0,
        ABM_REQ  = 3'h1,
        ABM_ADDR = 3'h2,
        ABM_DATA = 3'h3,
        ABM_ERR  = 3'h4
    } abm_state_t;

    abm_state_t  state_reg;
    logic [31:0] addr_reg;
    logic [3:0]  left_reg;
    logic [3:0]  beats_reg;
    logic        write_reg;
    logic [2:0]  size_reg;
    logic [3:0]  prot_reg;
    logic        swap_reg;
    logic [31:0] wdata_reg;
    logic        data_phase_reg;
    logic [1:0]  trans_reg;
    logic        rsp_valid_reg;
    logic [31:0] rsp_rdata_reg;
    logic        rsp_error_reg;
    logic        step;

    // Burst code from beat count; unsupported counts fall back to INCR.
    function automatic logic [2:0] burst_of(input logic [3:0] n);
        case (n)
            4'h1:    burst_of = abm_pkg::BURST_SINGLE;
            4'h4:    burst_of = abm_pkg::BURST_INCR4;
            4'h8:    burst_of = abm_pkg::BURST_INCR8;
            default: burst_of = abm_pkg::BURST_INCR;
        endcase
    endfunction

    // The bus advances only on an enabled edge with ready high.
    assign step = bus.bus_clock_enable && bus.hready;

    assign REQ_READY_O = (state_reg == ABM_IDLE) && !RST_I;

    // Main sequencer.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state_reg <= ABM_IDLE;
        end else begin
            case (state_reg)
                ABM_IDLE: begin
                    if (REQ_VALID_I) state_reg <= ABM_REQ;
                end
                ABM_REQ: begin
                    if (step && bus.hgrant) state_reg <= ABM_ADDR;
                end
                ABM_ADDR: begin
                    if (step && left_reg == 4'h1) state_reg <= ABM_DATA;
                end
                ABM_DATA: begin
                    if (bus.bus_clock_enable) begin
                        if (bus.hresp != abm_pkg::RESP_OKAY && !bus.hready)
                            state_reg <= ABM_ERR;
                        else if (bus.hready)
                            state_reg <= ABM_IDLE;
                    end
                end
                ABM_ERR: begin
                    if (step) state_reg <= ABM_IDLE;
                end
                default: state_reg <= ABM_IDLE;
            endcase
        end
    end

    // Capture of the request; held for the whole transfer, except address and beats left, which step per beat.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            addr_reg  <= abm_pkg::ADDR_RST;
            left_reg  <= 4'h0;
            beats_reg <= 4'h0;
            write_reg <= 1'b0;
            size_reg  <= abm_pkg::SIZE_WORD;
            prot_reg  <= 4'h0;
            swap_reg  <= 1'b0;
            wdata_reg <= abm_pkg::DATA_RST;
        end else if (state_reg == ABM_IDLE && REQ_VALID_I) begin
            addr_reg  <= REQ_ADDR_I;
            left_reg  <= (REQ_BEATS_I == 4'h0) ? 4'h1 : REQ_BEATS_I;
            beats_reg <= (REQ_BEATS_I == 4'h0) ? 4'h1 : REQ_BEATS_I;
            write_reg <= REQ_WRITE_I;
            // Size 3 is not a legal port size, so it is clipped to word.
            size_reg  <= (REQ_SIZE_I == 2'h3) ? abm_pkg::SIZE_WORD
                                              : {1'b0, REQ_SIZE_I};
            prot_reg[abm_pkg::PROT_DATA] <= !REQ_FETCH_I;
            prot_reg[abm_pkg::PROT_PRIV] <= REQ_PRIV_I;
            prot_reg[abm_pkg::PROT_BUF]  <= REQ_BUF_I;
            prot_reg[abm_pkg::PROT_CACH] <= REQ_CACH_I;
            swap_reg  <= REQ_SWAP_I && !REQ_FETCH_I;
            wdata_reg <= REQ_WDATA_I;
        end else if (state_reg == ABM_ADDR && step) begin
            // Advance address only on a completed beat.
            addr_reg <= addr_reg + ({29'h0, size_reg} == 32'h0 ? 32'h1 :
                        (size_reg == abm_pkg::SIZE_HALF ? 32'h2 : 32'h4));
            left_reg <= left_reg - 4'h1;
        end
    end

    // Transfer type per cycle; first beat NONSEQ, later beats SEQ.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            trans_reg <= abm_pkg::TRANS_IDLE;
        end else if (state_reg == ABM_REQ && step && bus.hgrant) begin
            trans_reg <= abm_pkg::TRANS_NONSEQ;
        end else if (state_reg == ABM_ADDR && step) begin
            trans_reg <= (left_reg == 4'h1) ? abm_pkg::TRANS_IDLE
                                            : abm_pkg::TRANS_SEQ;
        end else if (state_reg == ABM_DATA && bus.bus_clock_enable &&
                     bus.hresp != abm_pkg::RESP_OKAY && !bus.hready) begin
            // First error cycle of the last beat's data phase: hold the transfer type at IDLE.
            trans_reg <= abm_pkg::TRANS_IDLE;
        end
    end

    // Data phase tracks the beat whose address was just accepted.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            data_phase_reg <= 1'b0;
        end else if (step) begin
            data_phase_reg <= (state_reg == ABM_ADDR);
        end
    end

    // Answer to the user: one pulse when the last beat completes.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= abm_pkg::DATA_RST;
            rsp_error_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= 1'b0;
            if (data_phase_reg && step) begin
                rsp_rdata_reg <= bus.hrdata;
                // Retry and split are reported as errors; no reissue.
                rsp_error_reg <= rsp_error_reg ||
                                 bus.hresp != abm_pkg::RESP_OKAY;
                if (state_reg != ABM_ADDR) rsp_valid_reg <= 1'b1;
            end else if (state_reg == ABM_IDLE) begin
                rsp_error_reg <= 1'b0;
            end
        end
    end

    // Bus outputs; request stays up until the last address is taken.
    assign bus.hbusreq = (state_reg == ABM_REQ) ||
                         (state_reg == ABM_ADDR);
    assign bus.hlock   = swap_reg && (state_reg != ABM_IDLE);
    assign bus.haddr   = addr_reg;
    assign bus.htrans  = trans_reg;
    assign bus.hburst  = burst_of(beats_reg);
    assign bus.hsize   = size_reg;
    assign bus.hprot   = prot_reg;
    assign bus.hwrite  = write_reg;
    assign bus.hwdata  = wdata_reg;
    assign RSP_VALID_O = rsp_valid_reg;
    assign RSP_RDATA_O = rsp_rdata_reg;
    assign RSP_ERROR_O = rsp_error_reg;
endmodule

// ==== logic/abm_system.sv ====
// Far end of the bus: arbiter, one slave with a small word memory.
// Assumes the same clock and reset as the master port.
module abm_system #(
    parameter int WAITS = abm_pkg::WAIT_DEF,
    parameter int DEPTH = 16
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    abm_if.system            bus,
    input  wire logic        OTHER_REQ_I,
    input  wire logic [31:0] ERR_ADDR_I,
    output logic             OTHER_GRANT_O
);
    // Elaboration checks. Read data comes from a register, so at least one
    // wait state is needed for the word on the bus to be the addressed one.
    if (WAITS < 1 || WAITS > 15) begin : g_waits_check
        $error("WAITS out of range");
    end
    if (DEPTH < 2 || DEPTH > 256) begin : g_depth_check
        $error("DEPTH out of range");
    end

    logic        grant_reg;
    logic        dphase_reg;
    logic        dwrite_reg;
    logic [31:0] daddr_reg;
    logic [3:0]  wait_reg;
    logic        err_reg;
    logic [31:0] rdata_reg;
    logic [31:0] mem_reg [DEPTH];
    logic        done;
    logic        bad;
    logic [$clog2(DEPTH)-1:0] idx;

    // The same enable drives every bus edge here; ratio is one.
    assign bus.bus_clock_enable = 1'b1;

    assign idx  = daddr_reg[$clog2(DEPTH)+1:2];
    assign bad  = dphase_reg && daddr_reg == ERR_ADDR_I;
    assign done = !dphase_reg || (wait_reg == 4'h0 && (!bad || err_reg));

    // Arbiter: ownership moves only on ready; never while locked. The lock
    // freezes the grant only once the locking master holds it, because a
    // lock raised together with the request must not stall that request.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            grant_reg <= 1'b0;
        end else if (done && !(bus.hlock && grant_reg)) begin
            grant_reg <= bus.hbusreq || !OTHER_REQ_I;
        end
    end

    // Slave data phase with counted wait states and two-cycle error.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            daddr_reg  <= 32'h0;
            wait_reg   <= 4'h0;
            err_reg    <= 1'b0;
        end else if (done) begin
            dphase_reg <= grant_reg && bus.htrans[1];
            dwrite_reg <= bus.hwrite;
            daddr_reg  <= bus.haddr;
            wait_reg   <= 4'(WAITS);
            err_reg    <= 1'b0;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end else begin
            err_reg <= bad;
        end
    end

    // Storage and read data for the addressed word.
    always_ff @(posedge MCLK_I) begin
        if (dphase_reg && done && dwrite_reg && !bad) begin
            mem_reg[idx] <= bus.hwdata;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) rdata_reg <= 32'h0;
        else rdata_reg <= mem_reg[idx];
    end

    assign bus.hgrant   = grant_reg;
    assign bus.hready   = done;
    assign bus.hresp    = (bad) ? abm_pkg::RESP_ERROR
                                : abm_pkg::RESP_OKAY;
    assign bus.hrdata   = rdata_reg;
    assign OTHER_GRANT_O = !grant_reg;
endmodule

// ==== pkg/abm_if.sv ====
// Bus signals between the master port and the far end.
// Assumes one system clock; the bench drives clock and reset.
interface abm_if;
    logic [31:0] haddr;
    logic [2:0]  hburst;
    logic        hbusreq;
    logic        hgrant;
    logic        hlock;
    logic [3:0]  hprot;
    logic [31:0] hrdata;
    logic        hready;
    logic [1:0]  hresp;
    logic [2:0]  hsize;
    logic [1:0]  htrans;
    logic [31:0] hwdata;
    logic        hwrite;
    logic        bus_clock_enable;

    modport master (
        output haddr, hburst, hbusreq, hlock, hprot, hsize, htrans,
               hwdata, hwrite,
        input  hgrant, hrdata, hready, hresp, bus_clock_enable
    );
    modport system (
        input  haddr, hburst, hbusreq, hlock, hprot, hsize, htrans,
               hwdata, hwrite,
        output hgrant, hrdata, hready, hresp, bus_clock_enable
    );
endinterface

// ==== pkg/abm_pkg.sv ====
// Shared encodings and widths for the bus master port and its far end.
// Assumes both ends are clocked by one rising-edge system clock.
package abm_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Burst encodings; wrapping and sixteen-beat codes are never issued.
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR   = 3'h1;
    localparam logic [2:0] BURST_INCR4  = 3'h3;
    localparam logic [2:0] BURST_INCR8  = 3'h5;
    // Transfer sizes; bit 2 is always low.
    localparam logic [2:0] SIZE_BYTE  = 3'h0;
    localparam logic [2:0] SIZE_HALF  = 3'h1;
    localparam logic [2:0] SIZE_WORD  = 3'h2;
    // Transfer types.
    localparam logic [1:0] TRANS_IDLE   = 2'h0;
    localparam logic [1:0] TRANS_BUSY   = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;
    // Slave responses.
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERROR = 2'h1;
    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_SPLIT = 2'h3;
    // Protection field bit positions.
    localparam int PROT_DATA = 0;
    localparam int PROT_PRIV = 1;
    localparam int PROT_BUF  = 2;
    localparam int PROT_CACH = 3;
    // Reset values of the master's outputs.
    localparam logic [31:0] ADDR_RST = 32'h0;
    localparam logic [31:0] DATA_RST = 32'h0;
    // Far-end wait states inserted per beat by default.
    localparam int WAIT_DEF = 1;
endpackage

// ==== verif/abm_asserts.sv ====
// Concurrent checks on the bus between the master port and the far end.
// Assumes tb instantiates it beside the interface and feeds clock, reset.
module abm_asserts (
    input wire logic        MCLK_I,
    input wire logic        RST_I,
    input wire logic [31:0] haddr,
    input wire logic [2:0]  hburst,
    input wire logic        hbusreq,
    input wire logic        hgrant,
    input wire logic        hlock,
    input wire logic        hready,
    input wire logic [1:0]  hresp,
    input wire logic [2:0]  hsize,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        bus_clock_enable
);
    // One clock domain, so clock and reset are stated once here.
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    // A transfer begins with NONSEQ straight after an idle cycle.
    sequence s_start;
        htrans == abm_pkg::TRANS_NONSEQ && $past(htrans) == 2'h0;
    endsequence
    // A later beat follows an accepted address phase of the same burst.
    sequence s_next_beat;
        htrans == abm_pkg::TRANS_SEQ && $past(hready) && $past(htrans[1]);
    endsequence

    a_size_legal: assert property (!hsize[2] && hsize != 3'h3)
        else $error("transfer size out of range");
    a_burst_legal: assert property (htrans[1] |->
        hburst inside {3'h0, 3'h1, 3'h3, 3'h5})
        else $error("illegal burst code");
    a_start_granted: assert property (s_start |->
        $past(hgrant && hready && bus_clock_enable))
        else $error("bus taken without grant and ready");
    a_start_requested: assert property (s_start |-> $past(hbusreq))
        else $error("bus taken without request");
    // Waits with an error in flight may legally cancel, so OKAY only.
    a_hold_on_wait: assert property (htrans[1] && !hready &&
        hresp == abm_pkg::RESP_OKAY |=> $stable(haddr) && $stable(htrans)
        && $stable(hwrite) && $stable(hsize))
        else $error("control moved during wait");
    a_seq_addr_step: assert property (s_next_beat |->
        haddr == $past(haddr) + (32'h1 << hsize))
        else $error("burst address step wrong");
    a_lock_keeps_grant: assert property (hlock && hgrant |=> hgrant)
        else $error("grant lost while locked");
    a_bus_enable_on: assert property (bus_clock_enable)
        else $error("bus clock enable low");
endmodule

// ==== verif/tb.sv ====
// Self-checking bench joining the master port to the far end.
// Assumes the far end maps a small word memory and errors at err_addr.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK_I;
    logic        RST_I;
    logic        other_req;
    logic        req_valid;
    logic        req_write;
    logic        req_swap;
    logic [1:0]  req_size;
    logic [3:0]  req_beats;
    logic [3:0]  req_prot;
    logic [31:0] req_addr;
    logic [31:0] req_wdata;
    logic [31:0] rd;
    logic        rerr;
    logic [3:0]  mon_prot;
    logic [2:0]  mon_size;
    logic [2:0]  mon_burst;
    logic        mon_write;
    logic        lock_seen;
    int          beats;
    int          errors;
    int          n_compared;
    wire         req_ready;
    wire         rsp_valid;
    wire  [31:0] rsp_rdata;
    wire         rsp_error;
    const logic [31:0] err_addr = 32'h40;
    const logic [2:0]  bcode[4] = '{3'h0, 3'h1, 3'h3, 3'h5};
    const logic [3:0]  bnum[4]  = '{4'h1, 4'h2, 4'h4, 4'h8};

    abm_if bus ();
    abm_master i_abm_master (.MCLK_I(MCLK_I), .RST_I(RST_I), .bus(bus),
        .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready),
        .REQ_ADDR_I(req_addr), .REQ_WRITE_I(req_write),
        .REQ_SIZE_I(req_size), .REQ_BEATS_I(req_beats),
        .REQ_FETCH_I(~req_prot[0]), .REQ_PRIV_I(req_prot[1]),
        .REQ_BUF_I(req_prot[2]), .REQ_CACH_I(req_prot[3]),
        .REQ_SWAP_I(req_swap), .REQ_WDATA_I(req_wdata),
        .RSP_VALID_O(rsp_valid), .RSP_RDATA_O(rsp_rdata),
        .RSP_ERROR_O(rsp_error));
    abm_system i_abm_system (.MCLK_I(MCLK_I), .RST_I(RST_I), .bus(bus),
        .OTHER_REQ_I(other_req), .ERR_ADDR_I(err_addr), .OTHER_GRANT_O());
    abm_asserts i_abm_asserts (.MCLK_I(MCLK_I), .RST_I(RST_I),
        .haddr(bus.haddr), .hburst(bus.hburst), .hbusreq(bus.hbusreq),
        .hgrant(bus.hgrant), .hlock(bus.hlock), .hready(bus.hready),
        .hresp(bus.hresp), .hsize(bus.hsize), .htrans(bus.htrans),
        .hwrite(bus.hwrite), .bus_clock_enable(bus.bus_clock_enable));

    // A 5 ns period gives the 200 MHz system clock.
    initial begin
        MCLK_I = 1'b0;
        forever #2.5 MCLK_I = ~MCLK_I;
    end

    // Control of the first accepted beat is kept for later comparison.
    always @(posedge MCLK_I) begin
        if (bus.htrans == abm_pkg::TRANS_NONSEQ && bus.hready) begin
            mon_prot <= bus.hprot;
            mon_size <= bus.hsize;
            mon_burst <= bus.hburst;
            mon_write <= bus.hwrite;
        end
        if (bus.htrans[1] && bus.hready) beats <= beats + 1;
        if (bus.hlock) lock_seen <= 1'b1;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One whole request: offered at a falling edge, held until taken.
    task automatic xfer(input logic [31:0] a, input logic w,
        input logic [1:0] sz, input logic [3:0] nb, input logic [3:0] p,
        input logic sw, input logic [31:0] wd);
        int t;
        @(negedge MCLK_I);
        {req_addr, req_write, req_size, req_beats} = {a, w, sz, nb};
        {req_prot, req_swap, req_wdata} = {p, sw, wd};
        {beats, lock_seen, req_valid} = {32'd0, 1'b0, 1'b1};
        t = 0;
        while (req_ready !== 1'b1 && t++ < 200) @(negedge MCLK_I);
        @(negedge MCLK_I);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && t++ < 400) @(negedge MCLK_I);
        if (t >= 400) cmp(32'h0, 32'h1);
        rd = rsp_rdata;
        rerr = rsp_error;
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        {RST_I, other_req, req_valid, req_write, req_swap} = 5'h10;
        {req_size, req_beats, req_prot, req_addr, req_wdata} = '0;
        {errors, n_compared} = '0;
        repeat (3) @(negedge MCLK_I);
        RST_I = 1'b0;
        xfer(32'h10, 1'b1, 2'h2, 4'h1, 4'h1, 1'b0, 32'ha5c3_1e07);
        cmp(mon_write, 32'h1);
        xfer(32'h10, 1'b0, 2'h2, 4'h1, 4'h1, 1'b0, 32'h0);
        cmp(mon_write, 32'h0);
        cmp(rd, 32'ha5c3_1e07);
        $display("test write_read done");
        for (int s = 0; s < 3; s++) begin
            xfer(32'h20, 1'b0, s[1:0], 4'h1, 4'h1, 1'b0, 32'h0);
            cmp(mon_size, s);
        end
        $display("test sizes done");
        // Every documented burst code with its beat count and data.
        for (int i = 0; i < 4; i++) begin
            xfer(32'h0, 1'b1, 2'h2, bnum[i], 4'h1, 1'b0, 32'h1100 + i);
            cmp(mon_burst, bcode[i]);
            cmp(beats, bnum[i]);
            xfer({bnum[i] - 4'h1, 2'h0}, 1'b0, 2'h2, 4'h1, 4'h1, 1'b0, 0);
            cmp(rd, 32'h1100 + i);
        end
        $display("test bursts done");
        for (int p = 0; p < 16; p++) begin
            xfer(32'h4, 1'b0, 2'h2, 4'h1, p[3:0], 1'b0, 32'h0);
            cmp(mon_prot, p);
        end
        $display("test protection done");
        xfer(err_addr, 1'b0, 2'h2, 4'h1, 4'h1, 1'b0, 32'h0);
        cmp(rerr, 32'h1);
        xfer(32'h4, 1'b0, 2'h2, 4'h1, 4'h1, 1'b0, 32'h0);
        cmp(rerr, 32'h0);
        $display("test responses done");
        // A rival master asks throughout, so the lock is really tested.
        other_req = 1'b1;
        xfer(32'h8, 1'b1, 2'h2, 4'h1, 4'h1, 1'b1, 32'h5a5a_0f0f);
        cmp(lock_seen, 32'h1);
        xfer(32'h8, 1'b0, 2'h2, 4'h1, 4'h0, 1'b1, 32'h0);
        cmp(lock_seen, 32'h0);
        other_req = 1'b0;
        $display("test swap done");
        end_sim();
    end
endmodule
